// ---- inc/hport_defs.vh ----
// Constants for the drive side of the parallel host port
`ifndef HPORT_DEFS_VH
`define HPORT_DEFS_VH
// ----------------------------------------------------------------
// Bus widths
// ----------------------------------------------------------------
`define DATA_W        16
`define BYTE_W        8
`define ADDR_W        3
`define FIFO_DEPTH    32
`define FIFO_AW       5
// ----------------------------------------------------------------
// Register map (index = {cs1 block, address})
// ----------------------------------------------------------------
`define CMD_BLOCK     1'b0
`define CTL_BLOCK     1'b1
`define REG_DATA      3'h0
`define REG_ALTSTAT   3'h6
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_NS        10
`define WAIT_NS       60
`define WAIT_CYC      ((`WAIT_NS + `CLK_NS - 1) / `CLK_NS)
`define DASP_NS       20000
`define DASP_CYC      ((`DASP_NS) / `CLK_NS)
`endif

// ---- logic/word_fifo.v ----
// Word FIFO between the drive's data path and the host port
`timescale 1ns/1ns
module word_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 32,
   parameter AW    = 5
) (
   input  wire             clk,
   input  wire             rst_n,
   input  wire             ce,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [AW-1:0]    wp_r;
   reg [AW-1:0]    rp_r;
   reg [AW:0]      cnt_r;
   wire            push;
   wire            pop;
   assign in_ready  = (cnt_r != DEPTH[AW:0]);
   assign out_valid = (cnt_r != {(AW+1){1'b0}});
   assign out_data  = mem_r[rp_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   always @(posedge clk) begin
      if (ce && push) begin
         mem_r[wp_r] <= in_data;
      end
   end
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r  <= {AW{1'b0}};
         rp_r  <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else if (ce) begin
         if (push) begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop && !push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule

// ---- logic/drive_host_port.v ----
// Drive side of a 40-pin parallel host port
//
// Overview of operation
// (R1) Sixteen-bit shared data bus; all lines carry payload in data transfers.
// (R2) Register and ECC byte accesses use only the low eight data lines.
// (R3) Drive raises DMA request when ready to move data; host acknowledge pairs.
// (R4) Write strobe rising edge captures the data bus into addressed register.
// (R5) Drive drives addressed register while read strobe is low, else floats.
// (R6) In UltraDMA the host's read line is its ready or its strobe.
// (R7) Drive may hold IORDY low to insert wait states into host cycles.
// (R8) In UltraDMA the drive's IORDY line is its ready or its strobe.
// (R9) Host asserts DMA acknowledge in answer to the drive's DMA request.
// (R10) Drive raises interrupt request whenever it needs host attention.
// (R11) Passed-diagnostic driven as slave, only an input as master.
// (R12) Host holds reset low at power-up; drive treats it as hardware reset.
// (R13) Master or slave role taken from cable select when jumper fitted.
// (R14) Host selects one of eight registers with a three-bit address.
// (R15) Chip select 0 selects the command block registers.
// (R16) Chip select 1 selects the control registers.
// (R17) Activity/device-1 line is a time-multiplexed open-collector output.
// (R18) Host never asserts both chip selects, nor acknowledge, in register cycles.
`timescale 1ns/1ns
`include "hport_defs.vh"
module drive_host_port #(
   parameter DASP_CYCLES = `DASP_CYC
) (
   input  wire        CLK,
   input  wire        RSTN,
   input  wire        CE,
   input  wire        HRESET_N,
   input  wire [15:0] DD_IN,
   output reg  [15:0] DD_OUT,
   output wire        DD_OE_N,
   input  wire [2:0]  DA,
   input  wire        CS0_N,
   input  wire        CS1_N,
   input  wire        DIOW_N,
   input  wire        DIOR_N,
   output wire        IORDY_OUT,
   output wire        DMARQ,
   input  wire        DMACK_N,
   output wire        INTRQ,
   input  wire        CSEL,
   input  wire        CSEL_JUMPER,
   input  wire        SLAVE_JUMPER,
   input  wire        PDIAG_IN,
   output wire        PDIAG_OUT,
   output wire        PDIAG_OE_N,
   output wire        DASP_OUT,
   output wire        DASP_OE_N,
   input  wire        UDMA_EN,
   input  wire        UDMA_IN,
   input  wire        ATTN,
   input  wire        DIAG_OK,
   input  wire        ACTIVE,
   input  wire        DEV1_PRESENT,
   input  wire        SRC_VALID,
   output wire        SRC_READY,
   input  wire [15:0] SRC_DATA,
   output wire        SINK_VALID,
   output reg  [15:0] SINK_DATA,
   output wire [7:0]  REG_WDATA,
   output wire [3:0]  REG_WADDR,
   output wire        REG_WSTB,
   input  wire [7:0]  REG_RDATA,
   output wire [3:0]  REG_RADDR,
   output wire        PDIAG_SEEN,
   output wire        IS_SLAVE
);
   // ----------------------------------------------------------------
   // Synchronisers for every host pin
   // ----------------------------------------------------------------
   localparam NS = 29;
   wire [NS-1:0] raw = {HRESET_N, DD_IN, DA, CS0_N, CS1_N, DIOW_N, DIOR_N,
                        DMACK_N, CSEL, PDIAG_IN, CSEL_JUMPER, SLAVE_JUMPER};
   reg  [NS-1:0] s1_r;
   reg  [NS-1:0] s2_r;
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         s1_r <= {NS{1'b1}};
         s2_r <= {NS{1'b1}};
      end else if (CE) begin
         s1_r <= raw;
         s2_r <= s1_r;
      end
   end
   wire        hrst_n = s2_r[28];
   wire [15:0] dd     = s2_r[27:12];
   wire [2:0]  da     = s2_r[11:9];
   wire        cs0    = ~s2_r[8];
   wire        cs1    = ~s2_r[7];
   wire        wr     = ~s2_r[6];
   wire        rd     = ~s2_r[5];
   wire        ack    = ~s2_r[4];
   wire        csel   = s2_r[3];
   wire        pdiag  = ~s2_r[2];
   wire        cjmp   = s2_r[1];
   wire        sjmp   = s2_r[0];
   // ----------------------------------------------------------------
   // Strobe history, role, reset
   // ----------------------------------------------------------------
   reg wr_d_r, rd_d_r, slave_r, hr_d_r;
   reg [2:0] da_r;
   reg       blk_r;
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         wr_d_r  <= 1'b0;
         rd_d_r  <= 1'b0;
         slave_r <= 1'b0;
         // Idle level of the synchroniser, so no false release edge
         hr_d_r  <= 1'b1;
         da_r    <= 3'h0;
         blk_r   <= 1'b0;
      end else if (CE) begin
         wr_d_r <= wr;
         rd_d_r <= rd;
         hr_d_r <= hrst_n;
         // Role caught at host reset release, never mid-operation
         if (hrst_n && !hr_d_r) begin
            slave_r <= cjmp ? csel : sjmp; // (R13)
         end
         // Address held from strobe start so a late DA change cannot tear a write cycle; reads decode the live DA
         if ((wr && !wr_d_r) || (rd && !rd_d_r)) begin
            da_r  <= da; // (R14)
            blk_r <= cs1 ? `CTL_BLOCK : `CMD_BLOCK; // (R15) (R16)
         end
      end
   end
   assign IS_SLAVE = slave_r;
   function reg_sel;
      input c0;
      input c1;
      input a;
      begin
         reg_sel = (c0 ^ c1) & ~a; // (R18)
      end
   endfunction
   wire rsel     = reg_sel(cs0, cs1, ack);
   wire wr_rise  = wr_d_r & ~wr & hrst_n;
   wire data_reg = (blk_r == `CMD_BLOCK) && (da_r == `REG_DATA);
   // ----------------------------------------------------------------
   // Register writes and reads
   // ----------------------------------------------------------------
   assign REG_WDATA = dd[7:0]; // (R2)
   assign REG_WADDR = {blk_r, da_r};
   assign REG_WSTB  = CE & wr_rise & reg_sel(cs0, cs1, ack) & ~data_reg; // (R4)
   assign REG_RADDR = {cs1, da};
   // ----------------------------------------------------------------
   // Data path: PIO data register, DMA and UltraDMA bursts
   // ----------------------------------------------------------------
   wire       dma    = ack & UDMA_EN;
   wire       udma   = dma;
   wire       fo_v;
   wire [15:0] fo_d;
   reg        pop_r;
   reg        push_v_r;
   reg        got_r;
   localparam integer WAIT_LD = `WAIT_CYC;
   reg [`FIFO_AW:0] wait_r;
   reg        dstb_r;
   wire       in_rdy;
   wire       udma_out = udma & ~UDMA_IN;
   wire       udma_in  = udma & UDMA_IN;
   wire       h_edge   = (rd ^ rd_d_r);
   // Outbound words: register read of data reg, DMA read, or UltraDMA in burst
   wire take_out = (rsel & rd & ~rd_d_r & (cs0 && da == `REG_DATA))
                 | (ack & ~UDMA_EN & rd & ~rd_d_r)
                 | (udma_in & rd & wait_r == 0);  // (R6)
   // Inbound words: PIO data write, DMA write rising edge, or HSTROBE edge
   wire take_in  = (wr_rise & rsel & data_reg)
                 | (ack & ~UDMA_EN & wr_rise)
                 | (udma_out & h_edge); // (R6)
   word_fifo #(.WIDTH(`DATA_W), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_fifo (
      .clk       (CLK),
      .rst_n     (RSTN),
      .ce        (CE),
      .in_valid  (SRC_VALID),
      .in_ready  (SRC_READY),
      .in_data   (SRC_DATA),
      .out_valid (fo_v),
      .out_ready (pop_r),
      .out_data  (fo_d)
   );
   assign in_rdy     = 1'b1;
   assign SINK_VALID = push_v_r;
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         DD_OUT   <= 16'h0000;
         pop_r    <= 1'b0;
         push_v_r <= 1'b0;
         got_r    <= 1'b0;
         SINK_DATA <= 16'h0000;
         wait_r   <= 6'h00;
         dstb_r   <= 1'b1;
      end else if (CE) begin
         pop_r    <= 1'b0;
         push_v_r <= 1'b0;
         // Word already on the bus for this strobe: an empty buffer no longer stalls
         if (!rd) begin
            got_r <= 1'b0;
         end else if (take_out && fo_v) begin
            got_r <= 1'b1;
         end
         if (take_in) begin
            SINK_DATA <= dd; // (R1)
            push_v_r  <= in_rdy;
         end
         if (rsel && rd && !(cs0 && da == `REG_DATA)) begin
            DD_OUT <= {8'h00, REG_RDATA}; // (R2)
         end else if (take_out && fo_v) begin
            DD_OUT <= fo_d; // (R1)
            pop_r  <= 1'b1;
            if (udma_in) begin
               dstb_r <= ~dstb_r; // (R8)
            end
         end
         // Wait states: a short stretch after every taken word
         if (take_out || take_in) begin
            wait_r <= WAIT_LD[`FIFO_AW:0]; // (R7)
         end else if (wait_r != 0) begin
            wait_r <= wait_r - 1'b1;
         end
         if (!udma) begin
            dstb_r <= 1'b1;
         end
      end
   end
   // Read data released the cycle the strobe is seen negated
   assign DD_OE_N = ~((rsel | (ack & ~UDMA_EN) | udma_in) & rd & hrst_n); // (R5)
   // Empty FIFO in a read also stalls the host: wait state until data is there
   // UltraDMA paces itself with its own ready line, so only DMA and PIO reads wait here
   wire stall = (wait_r != 0)
              | (rd & ~got_r & ((ack & ~UDMA_EN) | (rsel & cs0 & da == `REG_DATA)) & ~fo_v);
   assign IORDY_OUT = udma_in  ? dstb_r :            // (R8)
                      udma_out ? ~stall : ~stall;    // (R7) (R8)
   // ----------------------------------------------------------------
   // Request, interrupt, diagnostic, activity
   // ----------------------------------------------------------------
   // Request only when a word can really move in the current direction
   assign DMARQ = hrst_n & (UDMA_IN ? fo_v : in_rdy) & (SRC_VALID | fo_v | ~UDMA_IN); // (R3) (R9)
   assign INTRQ = hrst_n & ATTN; // (R10) (R12)
   assign PDIAG_OUT  = 1'b0;
   assign PDIAG_OE_N = ~(slave_r & DIAG_OK & hrst_n); // (R11)
   assign PDIAG_SEEN = ~slave_r & pdiag; // (R11)
   reg [23:0] dasp_cnt_r;
   reg        dasp_ph_r;
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         dasp_cnt_r <= 24'h000000;
         dasp_ph_r  <= 1'b0;
      end else if (CE) begin
         if (dasp_cnt_r >= DASP_CYCLES - 1) begin
            dasp_cnt_r <= 24'h000000;
            dasp_ph_r  <= ~dasp_ph_r; // (R17)
         end else begin
            dasp_cnt_r <= dasp_cnt_r + 24'h000001;
         end
      end
   end
   // Open collector: only ever pulls low
   assign DASP_OUT  = 1'b0;
   assign DASP_OE_N = ~(dasp_ph_r ? (slave_r & DEV1_PRESENT) : ACTIVE); // (R17)
endmodule

// ---- dv/host_ctrl_model.sv ----
// Host controller model for the parallel host port
`timescale 1ns/1ns
module host_ctrl_model (
   input  wire        clk,
   input  wire [15:0] dd_out,
   input  wire        dd_oe_n,
   input  wire        iordy,
   output wire [15:0] dd_in,
   output reg  [2:0]  da,
   output reg         cs0_n,
   output reg         cs1_n,
   output reg         diow_n,
   output reg         dior_n,
   output reg         dmack_n
);
   reg [15:0] hd;
   int        ph = 8;
   int        tmo = 0;
   // Released bus shows the inverse of the last value, never a stale copy
   assign dd_in = dd_oe_n ? hd : dd_out;
   initial begin
      {da, hd} = 19'h0;
      {cs0_n, cs1_n, diow_n, dior_n, dmack_n} = 5'h1f;
   end
   task tick(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask
   // ----------
   // One strobe cycle; ph sets the phase length
   // ----------
   task cyc(input bit c0, c1, k, w, input [2:0] a, input [15:0] d, output [15:0] q);
      int i;
      {cs0_n, cs1_n, dmack_n, da} = {c0, c1, k, a};
      if (w)
         hd = d;
      tick(1);
      if (w)
         diow_n = 0;
      else
         dior_n = 0;
      tick(ph);
      for (i = 0; i < 200 && iordy !== 1'b1; i++) tick(1);
      if (iordy !== 1'b1)
         tmo++;
      q = dd_in;
      {diow_n, dior_n} = 2'h3;
      tick(6);
      {cs0_n, cs1_n, dmack_n} = 3'h7;
      hd = ~hd;
      tick(ph);
   endtask
   // ----------
   // UltraDMA out burst; each read-line edge carries a word
   // ----------
   task uout(input int n, input [15:0] d0);
      int i, j;
      dmack_n = 0;
      for (j = 0; j < n; j++) begin
         for (i = 0; i < 200 && iordy !== 1'b1; i++) tick(1);
         if (iordy !== 1'b1)
            tmo++;
         hd = d0 + 16'(j);
         tick(1);
         dior_n = ~dior_n;
         tick(ph);
      end
      tick(2);
      dmack_n = 1;
      tick(ph);
   endtask
endmodule

// ---- dv/drive_host_port_assertions.sv ----
// Concurrent checks on the drive side of the host port
`timescale 1ns/1ns
module drive_host_port_assertions (
   input wire       CLK,
   input wire       RSTN,
   input wire       HRESET_N,
   input wire [2:0] DA,
   input wire       CS0_N,
   input wire       CS1_N,
   input wire       DIOW_N,
   input wire       DIOR_N,
   input wire       DMACK_N,
   input wire       ATTN,
   input wire       DD_OE_N,
   input wire       DMARQ,
   input wire       INTRQ,
   input wire       REG_WSTB,
   input wire       IS_SLAVE,
   input wire       PDIAG_OE_N,
   input wire       DASP_OUT,
   input wire       DASP_OE_N,
   input wire       ACTIVE,
   input wire       DEV1_PRESENT
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);
   // ----------
   // Assertions
   // ----------
   pdiag_master_a: assert property (!IS_SLAVE [*2] |-> PDIAG_OE_N)
      else $error("pdiag driven as master");
   dasp_level_a: assert property (!DASP_OUT &&
      (DASP_OE_N || ACTIVE || (IS_SLAVE && DEV1_PRESENT)))
      else $error("dasp driven high or pulled without cause");
   intrq_cause_a: assert property (INTRQ |-> ATTN)
      else $error("intrq without cause");
   hreset_gate_a: assert property (!HRESET_N [*4] |-> !INTRQ && !DMARQ && DD_OE_N)
      else $error("outputs live in host reset");
   rd_float_a: assert property (DIOR_N [*5] |-> DD_OE_N)
      else $error("bus driven without read");
   wr_take_a: assert property ($rose(DIOW_N) && (CS0_N != CS1_N) && DMACK_N &&
      (CS0_N || DA != 3'h0) |-> ##[2:4] REG_WSTB) else $error("write not taken");
   wr_refuse_a: assert property ($rose(DIOW_N) && !CS0_N && !CS1_N |-> ##1 !REG_WSTB [*5])
      else $error("write with both selects");
   wstb_pulse_a: assert property (REG_WSTB |=> !REG_WSTB)
      else $error("write strobe too long");
   cover property (REG_WSTB);
   cover property (!DD_OE_N && !DMACK_N);
   cover property (!PDIAG_OE_N);
   cover property (!DASP_OE_N && !ACTIVE);
endmodule
bind drive_host_port drive_host_port_assertions asrt (.CLK, .RSTN, .HRESET_N, .DA, .CS0_N,
   .CS1_N, .DIOW_N, .DIOR_N, .DMACK_N, .ATTN, .DD_OE_N, .DMARQ, .INTRQ, .REG_WSTB, .IS_SLAVE,
   .PDIAG_OE_N, .DASP_OUT, .DASP_OE_N, .ACTIVE, .DEV1_PRESENT);

// ---- dv/ata_drive_host_port_test.sv ----
// Self-checking bench for the drive side of the host port
`timescale 1ns/1ns
module ata_drive_host_port_test;
   logic        CLK = 0, RSTN = 0, HRESET_N = 0, ATTN = 0, DIAG_OK = 1, SRC_VALID = 0;
   logic        CSEL = 0, CSEL_JUMPER = 0, SLAVE_JUMPER = 0;
   logic        CE = 1, UDMA_EN = 0, UDMA_IN = 0, ACTIVE = 0, DEV1_PRESENT = 0;
   logic [15:0] SRC_DATA = 16'h0;
   logic        other_pass = 0;
   wire  [15:0] DD_IN, DD_OUT, SINK_DATA;
   wire  [7:0]  REG_WDATA, REG_RDATA;
   wire  [3:0]  REG_WADDR, REG_RADDR;
   wire  [2:0]  DA;
   wire         CS0_N, CS1_N, DIOW_N, DIOR_N, DMACK_N, DD_OE_N, IORDY_OUT, DMARQ, INTRQ;
   wire         PDIAG_OUT, PDIAG_OE_N, DASP_OUT, DASP_OE_N, SRC_READY, SINK_VALID;
   wire         REG_WSTB, PDIAG_SEEN, IS_SLAVE, PDIAG_IN;
   int          comparisons = 0, mismatches = 0, wcnt = 0, scnt = 0;
   logic [11:0] wlast;
   logic [15:0] slast;
   // Register source answers from its address so each read is predictable
   assign REG_RDATA = {REG_RADDR ^ 4'ha, REG_RADDR};
   // Wired line: the drive's own pull and the other device's pass signal
   assign PDIAG_IN = (PDIAG_OE_N | PDIAG_OUT) & ~other_pass;
   initial forever #5 CLK = ~CLK;
   drive_host_port #(.DASP_CYCLES(4)) dut (.CLK, .RSTN, .CE, .HRESET_N, .DD_IN, .DD_OUT,
      .DD_OE_N, .DA, .CS0_N, .CS1_N, .DIOW_N, .DIOR_N, .IORDY_OUT, .DMARQ, .DMACK_N, .INTRQ,
      .CSEL, .CSEL_JUMPER, .SLAVE_JUMPER, .PDIAG_IN, .PDIAG_OUT, .PDIAG_OE_N, .DASP_OUT,
      .DASP_OE_N, .UDMA_EN, .UDMA_IN, .ATTN, .DIAG_OK, .ACTIVE, .DEV1_PRESENT, .SRC_VALID,
      .SRC_READY, .SRC_DATA, .SINK_VALID, .SINK_DATA, .REG_WDATA, .REG_WADDR, .REG_WSTB,
      .REG_RDATA, .REG_RADDR, .PDIAG_SEEN, .IS_SLAVE);
   host_ctrl_model host (.clk(CLK), .dd_out(DD_OUT), .dd_oe_n(DD_OE_N), .iordy(IORDY_OUT),
      .dd_in(DD_IN), .da(DA), .cs0_n(CS0_N), .cs1_n(CS1_N), .diow_n(DIOW_N),
      .dior_n(DIOR_N), .dmack_n(DMACK_N));
   always @(posedge CLK) begin
      if (REG_WSTB) begin
         wcnt <= wcnt + 1;
         wlast <= {REG_WADDR, REG_WDATA};
      end
      if (SINK_VALID) begin
         scnt <= scnt + 1;
         slast <= SINK_DATA;
      end
   end
   // ----------
   // Checks and scenarios
   // ----------
   task chk(input bit ok, input string msg);
      comparisons++;
      if (!ok) begin
         mismatches++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask
   task print_verdict;
      if (host.tmo != 0) begin
         mismatches += host.tmo;
         $display("BAD %0t host ready waits timed out", $time);
      end
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task t_reg;
      int k, n;
      bit c1;
      logic [2:0] a;
      logic [7:0] v;
      logic [15:0] q;
      for (k = 0; k < 9; k++) begin
         c1 = k > 6;
         a = c1 ? 3'(k - 1) : 3'(k + 1);
         v = 8'(k * 37 + 1);
         n = wcnt;
         host.cyc(c1, !c1, 1, 1, a, {8'hc3, v}, q);
         chk(wcnt == n + 1 && wlast === {c1, a, v}, "register write");
         host.cyc(c1, !c1, 1, 0, a, 16'h0, q);
         chk(q[7:0] === {{c1, a} ^ 4'ha, c1, a}, "register read");
      end
      n = wcnt;
      host.cyc(0, 0, 1, 1, 3'h2, 16'h0011, q);
      chk(wcnt == n, "both selects");
   endtask
   task t_data;
      int n, w;
      logic [15:0] q;
      n = scnt;
      w = wcnt;
      // Slow host: long strobe phases
      host.ph = 20;
      host.cyc(0, 1, 1, 1, 3'h0, 16'hbeef, q);
      host.ph = 8;
      chk(scnt == n + 1 && slast === 16'hbeef && wcnt == w, "data word in");
   endtask
   task wait_req;
      int i;
      for (i = 0; i < 100 && DMARQ !== 1'b1; i++) host.tick(1);
      if (DMARQ !== 1'b1) begin
         mismatches++;
         $display("BAD %0t no request", $time);
         print_verdict;
      end
   endtask
   task t_fifo;
      int n, i;
      logic [15:0] q;
      // Drive-to-host direction, so the request follows the buffered words
      UDMA_IN = 1;
      for (n = 0; n < 40 && SRC_READY; n++) begin
         SRC_VALID = 1;
         SRC_DATA = 16'h1000 + 16'(n);
         host.tick(1);
      end
      SRC_VALID = 0;
      chk(n == 32, "buffer depth");
      for (i = 0; i < 32; i++) begin
         wait_req;
         host.cyc(1, 1, 0, 0, 3'h0, 16'h0, q);
         chk(q === 16'h1000 + 16'(i), "dma word out");
      end
      host.tick(10);
      chk(DMARQ === 1'b0, "request after drain");
      UDMA_IN = 0;
   endtask
   task t_udma;
      int n;
      n = scnt;
      UDMA_EN = 1;
      host.uout(4, 16'h5a00);
      UDMA_EN = 0;
      chk(scnt == n + 4 && slast === 16'h5a03, "ultra dma words in");
   endtask
   task t_dasp;
      int i, k, n;
      for (k = 0; k < 4; k++) begin
         ACTIVE = (k != 2);
         DEV1_PRESENT = (k == 1 || k == 2);
         CE = (k != 3);
         n = 0;
         for (i = 0; i < 8; i++) begin
            host.tick(1);
            n += !DASP_OE_N;
         end
         if (k == 3)
            chk(n == 0 || n == 8, "activity frozen by enable");
         else
            chk(n == (k == 1 ? 8 : 4), "activity multiplex");
      end
      CE = 1;
      ACTIVE = 0;
      DEV1_PRESENT = 0;
   endtask
   task hres;
      HRESET_N = 0;
      host.tick(4);
      chk(INTRQ === 1'b0 && DMARQ === 1'b0, "host reset gating");
      HRESET_N = 1;
      host.tick(6);
   endtask
   task t_role;
      ATTN = 1;
      SLAVE_JUMPER = 1;
      hres;
      chk(INTRQ === 1'b1, "attention");
      chk(IS_SLAVE && PDIAG_OE_N === 1'b0 && PDIAG_OUT === 1'b0, "jumper slave");
      CSEL_JUMPER = 1;
      hres;
      chk(IS_SLAVE === 1'b0 && PDIAG_OE_N === 1'b1, "cable master");
      other_pass = 1;
      host.tick(4);
      chk(PDIAG_SEEN === 1'b1, "other device pass seen");
      other_pass = 0;
      CSEL = 1;
      ATTN = 0;
      hres;
      chk(IS_SLAVE === 1'b1 && INTRQ === 1'b0, "cable slave");
      DIAG_OK = 0;
      host.tick(1);
      chk(PDIAG_OE_N === 1'b1 && PDIAG_SEEN === 1'b0, "failed diagnostic quiet");
      DIAG_OK = 1;
   endtask
   initial begin
      host.tick(6);
      RSTN = 1;
      HRESET_N = 1;
      host.tick(4);
      t_reg;
      t_data;
      t_fifo;
      t_udma;
      t_role;
      t_dasp;
      print_verdict;
   end
endmodule
